// File: rtl/frs_consts.svh
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH
// wishbone word offsets (byte addresses)
`define FRS_OFF_STATUS_ONE 8'h00
`define FRS_OFF_STATUS_TWO 8'h04
`define FRS_OFF_RESULT_ZERO 8'h08
`define FRS_OFF_CONTROL 8'h0c
// status one bit positions
`define FRS_S1_END_CYL 7
`define FRS_S1_CRC_ANY 5
`define FRS_S1_OVERRUN 4
`define FRS_S1_SECT_MISS 2
`define FRS_S1_WR_BLOCK 1
`define FRS_S1_ID_LOST 0
// status two bit positions
`define FRS_S2_DEL_SEEN 6
`define FRS_S2_CRC_PAY 5
`define FRS_S2_TRK_MISM 4
`define FRS_S2_SCAN_EQ 3
`define FRS_S2_SCAN_UNMET 2
`define FRS_S2_BAD_TRK 1
`define FRS_S2_PAY_LOST 0
// always-zero masks
`define FRS_S1_USED_MASK 8'hb7
`define FRS_S2_USED_MASK 8'h7f
// termination codes (bits 7:6 of result byte zero)
`define FRS_TERM_NORMAL 2'h0
`define FRS_TERM_ABNORMAL 2'h1
`define FRS_TERM_INVALID 2'h2
`define FRS_BAD_CYL_VALUE 8'hff
`define FRS_REG_RESET 8'h00
`endif

// File: rtl/frs_pkg.sv
package frs_pkg;
	typedef enum logic [2:0] {
		FRS_CMD_READ = 3'h0,
		FRS_CMD_WRITE = 3'h1,
		FRS_CMD_WRITE_DEL = 3'h2,
		FRS_CMD_SCAN = 3'h3,
		FRS_CMD_READ_ID = 3'h4,
		FRS_CMD_READ_TRACK = 3'h5,
		FRS_CMD_FORMAT = 3'h6,
		FRS_CMD_OTHER = 3'h7
	} frs_cmd_type;
	// one-cycle event pulses from the execution engine
	typedef struct packed {
		logic past_last_sector;
		logic id_crc_bad;
		logic data_crc_bad;
		logic host_late;
		logic sector_not_found;
		logic no_good_id;
		logic start_sector_missing;
		logic write_protect;
		logic index_twice_no_id;
		logic no_data_mark;
		logic deleted_mark;
		logic scan_equal;
		logic scan_none;
		logic cyl_compare;
		logic [7:0] cyl_on_medium;
		logic [7:0] cyl_target;
	} frs_event_type;
	typedef enum logic [2:0] {
		FRS_IDLE = 3'b001,
		FRS_EXEC = 3'b010,
		FRS_RESULT = 3'b100
	} frs_state_type;
endpackage

// File: rtl/frs_status_flags.sv
`timescale 1ns/100ps
`include "frs_consts.svh"
// Overview of operation
// - set status one bit 7 on access beyond cylinder's last sector
// - status one bits 6 and 3 always read zero
// - set status one bit 5 on id or data crc failure
// - set status one bit 4 when host misses a byte transfer deadline
// - read, write-deleted, scan: set status one bit 2 if target sector absent
// - read-track: set status one bit 2 if starting sector not located
// - write, write-deleted, format: set status one bit 1 on write protect
// - set status one bit 0 when index seen twice without id mark
// - missing data mark sets status one bit 0 and status two bit 0 together
// - status two bit 7 always reads zero
// - read or scan: set status two bit 6 on deleted-data mark
// - set status two bit 5 on data field crc failure
// - with sector-missing, set status two bit 4 on cylinder mismatch
// - scan: set status two bit 3 when equal condition met
// - scan: set status two bit 2 when no sector meets condition
// - set status two bit 1 on cylinder mismatch with recorded value ff
// - any command: set status two bit 0 if no data or deleted mark found
// - started but failed command reports abnormal code in result byte zero
module frs_status_flags
	import frs_pkg::*;
(
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	// execution engine
	input wire logic CMD_START_I,
	input wire logic CMD_END_I,
	input wire logic CMD_INVALID_I,
	input wire frs_cmd_type CMD_KIND_I,
	input wire frs_event_type EVT_I,
	// status to sequencer
	output logic [7:0] STATUS_ONE_O,
	output logic [7:0] STATUS_TWO_O,
	output logic RESULT_READY_O
);

	logic [7:0] status_one;
	logic [7:0] status_two;
	logic [1:0] term_code;
	logic fail_on_ended;
	logic hold_result;
	frs_state_type state;
	frs_state_type next_state;
	logic [7:0] next_one;
	logic [7:0] next_two;
	logic cmd_reads;
	logic cmd_scan;
	logic cmd_writes;
	logic cmd_search;
	logic cyl_mismatch;
	logic bus_req;
	logic [31:0] next_rdata;
	logic next_err;

	// same compare used for both mismatch flags
	function automatic logic cyl_differs(input logic [7:0] a, input logic [7:0] b);
		return a != b;
	endfunction

	// command classes, shared by several flag rules
	function automatic logic is_scan(input frs_cmd_type k);
		return k == FRS_CMD_SCAN;
	endfunction

	function automatic logic is_read_class(input frs_cmd_type k);
		// scans read the sector before comparing, so they count as reads
		return (k == FRS_CMD_READ) || is_scan(k);
	endfunction

	function automatic logic is_write_class(input frs_cmd_type k);
		// format writes the whole track and is blocked by protect like a write
		return (k == FRS_CMD_WRITE) || (k == FRS_CMD_WRITE_DEL) || (k == FRS_CMD_FORMAT);
	endfunction

	function automatic logic is_search_class(input frs_cmd_type k);
		// commands that hunt for one named sector
		return is_read_class(k) || (k == FRS_CMD_WRITE_DEL);
	endfunction

	assign cmd_scan = is_scan(CMD_KIND_I);
	assign cmd_reads = is_read_class(CMD_KIND_I);
	assign cmd_writes = is_write_class(CMD_KIND_I);
	assign cmd_search = is_search_class(CMD_KIND_I);
	assign cyl_mismatch = EVT_I.cyl_compare && cyl_differs(EVT_I.cyl_on_medium, EVT_I.cyl_target);

	// command phase tracking
	always_comb begin
		next_state = state;
		case (state)
			FRS_IDLE: begin
				if (CMD_START_I) begin
					next_state = FRS_EXEC;
				end
			end
			FRS_EXEC: begin
				if (CMD_END_I) begin
					next_state = FRS_RESULT;
				end
			end
			FRS_RESULT: begin
				if (CMD_START_I) begin
					next_state = FRS_EXEC;
				end
			end
			default: begin
				next_state = FRS_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= FRS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// sticky flag accumulation; events only count while executing
	always_comb begin
		next_one = status_one;
		next_two = status_two;
		if (CMD_START_I) begin
			next_one = `FRS_REG_RESET;
			next_two = `FRS_REG_RESET;
		end else if (state == FRS_EXEC) begin
			if (EVT_I.past_last_sector) begin
				next_one[`FRS_S1_END_CYL] = 1'b1;
			end
			if (EVT_I.id_crc_bad || EVT_I.data_crc_bad) begin
				next_one[`FRS_S1_CRC_ANY] = 1'b1;
			end
			if (EVT_I.data_crc_bad) begin
				next_two[`FRS_S2_CRC_PAY] = 1'b1;
			end
			if (EVT_I.host_late) begin
				next_one[`FRS_S1_OVERRUN] = 1'b1;
			end
			if (EVT_I.sector_not_found && cmd_search) begin
				next_one[`FRS_S1_SECT_MISS] = 1'b1;
			end
			if (EVT_I.no_good_id && CMD_KIND_I == FRS_CMD_READ_ID) begin
				next_one[`FRS_S1_SECT_MISS] = 1'b1;
			end
			if (EVT_I.start_sector_missing && CMD_KIND_I == FRS_CMD_READ_TRACK) begin
				next_one[`FRS_S1_SECT_MISS] = 1'b1;
			end
			if (EVT_I.write_protect && cmd_writes) begin
				next_one[`FRS_S1_WR_BLOCK] = 1'b1;
			end
			if (EVT_I.index_twice_no_id) begin
				next_one[`FRS_S1_ID_LOST] = 1'b1;
			end
			if (EVT_I.no_data_mark) begin
				next_one[`FRS_S1_ID_LOST] = 1'b1;
				next_two[`FRS_S2_PAY_LOST] = 1'b1;
			end
			if (EVT_I.deleted_mark && cmd_reads) begin
				next_two[`FRS_S2_DEL_SEEN] = 1'b1;
			end
			// mismatch is reported alongside the sector-missing flag
			if (cyl_mismatch) begin
				next_two[`FRS_S2_TRK_MISM] = 1'b1;
				next_one[`FRS_S1_SECT_MISS] = 1'b1;
				if (EVT_I.cyl_on_medium == `FRS_BAD_CYL_VALUE) begin
					next_two[`FRS_S2_BAD_TRK] = 1'b1;
				end
			end
			if (EVT_I.scan_equal && cmd_scan) begin
				next_two[`FRS_S2_SCAN_EQ] = 1'b1;
			end
			if (EVT_I.scan_none && cmd_scan) begin
				next_two[`FRS_S2_SCAN_UNMET] = 1'b1;
			end
		end
		next_one = next_one & `FRS_S1_USED_MASK;
		next_two = next_two & `FRS_S2_USED_MASK;
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			status_one <= `FRS_REG_RESET;
			status_two <= `FRS_REG_RESET;
		end else begin
			status_one <= next_one;
			status_two <= next_two;
		end
	end

	// any error flag at the end marks the command as abnormally ended;
	// scan-equal is a result, not an error, so it is left out
	always_comb begin
		fail_on_ended = 1'b0;
		if (next_one != 8'h00) begin
			fail_on_ended = 1'b1;
		end
		if ((next_two & ~(8'h01 << `FRS_S2_SCAN_EQ)) != 8'h00) begin
			fail_on_ended = 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			term_code <= `FRS_TERM_NORMAL;
		end else if (CMD_INVALID_I) begin
			term_code <= `FRS_TERM_INVALID;
		end else if (CMD_START_I) begin
			term_code <= `FRS_TERM_NORMAL;
		end else if (state == FRS_EXEC && CMD_END_I) begin
			term_code <= fail_on_ended ? `FRS_TERM_ABNORMAL : `FRS_TERM_NORMAL;
		end
	end

	// result is held for the host until the next command starts
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			hold_result <= 1'b0;
		end else if (CMD_START_I) begin
			hold_result <= 1'b0;
		end else if (state == FRS_EXEC && CMD_END_I) begin
			hold_result <= 1'b1;
		end
	end

	assign STATUS_ONE_O = status_one;
	assign STATUS_TWO_O = status_two;
	assign RESULT_READY_O = hold_result;

	// wishbone: one registered answer per request, one cycle after the strobe, dropped the cycle after
	assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (WB_ADR_I == `FRS_OFF_STATUS_ONE) begin
			next_rdata = {24'h00_0000, status_one};
			next_err = WB_WE_I;
		end else if (WB_ADR_I == `FRS_OFF_STATUS_TWO) begin
			next_rdata = {24'h00_0000, status_two};
			next_err = WB_WE_I;
		end else if (WB_ADR_I == `FRS_OFF_RESULT_ZERO) begin
			next_rdata = {24'h00_0000, term_code, 6'h00};
			next_err = WB_WE_I;
		end else if (WB_ADR_I == `FRS_OFF_CONTROL) begin
			next_rdata = {29'h0000_0000, state == FRS_EXEC, hold_result, state == FRS_IDLE};
			next_err = WB_WE_I;
		end else begin
			next_err = 1'b1;
		end
	end

	// acknowledge: one pulse per accepted read
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req && !next_err;
		end
	end

	// error: writes and unmapped offsets, one pulse per request
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WB_ERR_O <= 1'b0;
		end else begin
			WB_ERR_O <= bus_req && next_err;
		end
	end

	// read data holds after the answer so a slow master can still pick it up
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (bus_req && !next_err) begin
			WB_DAT_O <= next_rdata;
		end
	end

endmodule

// File: test/frs_host_model.sv
`timescale 1ns/100ps
module frs_host_model (
	// bench side
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic go_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	output logic done_o,
	output logic [31:0] dat_o,
	output logic err_o,
	// wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i,
	input wire logic err_i
);
	// one request at a time; the released address is inverted so stale decode shows
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
			cyc_o <= 1'b0;
			stb_o <= 1'b0;
			we_o <= 1'b0;
			adr_o <= 8'hff;
			dat_o <= 32'h0000_0000;
			err_o <= 1'b0;
		end else if (cyc_o && (ack_i || err_i)) begin
			cyc_o <= 1'b0;
			stb_o <= 1'b0;
			adr_o <= ~adr_o;
			dat_o <= dat_i;
			err_o <= err_i;
			done_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			if (go_i) begin
				cyc_o <= 1'b1;
				stb_o <= 1'b1;
				we_o <= we_i;
				adr_o <= adr_i;
			end
		end
	end
endmodule

// File: test/frs_status_flags_monitor.sv
`timescale 1ns/100ps
module frs_flags_chk
	import frs_pkg::*;
(
	// watched ports
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic WB_ERR_O,
	input wire logic CMD_START_I,
	input wire logic CMD_END_I,
	input wire frs_cmd_type CMD_KIND_I,
	input wire frs_event_type EVT_I,
	input wire logic [7:0] STATUS_ONE_O,
	input wire logic [7:0] STATUS_TWO_O
);
	logic ex;
	logic h;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	// events only count between start and end; start beats a same-cycle event
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ex <= 1'b0;
		end else if (CMD_START_I) begin
			ex <= 1'b1;
		end else if (CMD_END_I) begin
			ex <= 1'b0;
		end
	end
	assign h = ex && !CMD_START_I;
	AST_S1_ZERO: assert property (STATUS_ONE_O[6] == 1'b0 && STATUS_ONE_O[3] == 1'b0)
		else $error("status one spare bit set");
	AST_S2_ZERO: assert property (STATUS_TWO_O[7] == 1'b0)
		else $error("status two spare bit set");
	AST_CLR: assert property (CMD_START_I |=> STATUS_ONE_O == 8'h00 && STATUS_TWO_O == 8'h00)
		else $error("status not cleared");
	AST_END_CYL: assert property (h && EVT_I.past_last_sector |=> STATUS_ONE_O[7])
		else $error("end of cylinder flag");
	AST_CRC: assert property (h && EVT_I.data_crc_bad |=> STATUS_ONE_O[5] && STATUS_TWO_O[5])
		else $error("crc flags");
	AST_LATE: assert property (h && EVT_I.host_late |=> STATUS_ONE_O[4])
		else $error("overrun flag");
	AST_WP: assert property (h && EVT_I.write_protect
		&& CMD_KIND_I inside {FRS_CMD_WRITE, FRS_CMD_WRITE_DEL, FRS_CMD_FORMAT} |=> STATUS_ONE_O[1])
		else $error("write block flag");
	AST_NO_MARK: assert property (h && EVT_I.no_data_mark |=> STATUS_ONE_O[0] && STATUS_TWO_O[0])
		else $error("missing mark flags");
	AST_BAD_CYL: assert property (h && EVT_I.cyl_compare && EVT_I.cyl_on_medium == 8'hff
		&& EVT_I.cyl_target != 8'hff |=> STATUS_TWO_O[4] && STATUS_TWO_O[1])
		else $error("cylinder flags");
	AST_SCAN_EQ: assert property (h && EVT_I.scan_equal && CMD_KIND_I == FRS_CMD_SCAN
		|=> STATUS_TWO_O[3])
		else $error("scan equal flag");
	AST_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
		|=> WB_ACK_O != WB_ERR_O ##1 !WB_ACK_O && !WB_ERR_O)
		else $error("bus answer");
endmodule
bind frs_status_flags frs_flags_chk u_chk (.MCLK_I, .RSTN_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
	.WB_ERR_O, .CMD_START_I, .CMD_END_I, .CMD_KIND_I, .EVT_I, .STATUS_ONE_O, .STATUS_TWO_O);

// File: test/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	import frs_pkg::*;
	logic MCLK_I = 1'b0;
	logic RSTN_I = 1'b0;
	logic cyc, stb, we, ack, err, done, herr, rdy;
	logic go = 1'b0;
	logic start = 1'b0;
	logic fin = 1'b0;
	logic inv = 1'b0;
	logic [7:0] adr, s1, s2;
	logic [31:0] dat, hdat;
	frs_cmd_type kind = FRS_CMD_READ;
	frs_event_type evt = '0;
	int fail_count = 0;
	int checked = 0;
	initial begin
		forever #5 MCLK_I = ~MCLK_I;
	end
	frs_status_flags dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(32'h0), .WB_DAT_O(dat),
		.WB_ACK_O(ack), .WB_ERR_O(err), .CMD_START_I(start), .CMD_END_I(fin),
		.CMD_INVALID_I(inv), .CMD_KIND_I(kind), .EVT_I(evt), .STATUS_ONE_O(s1),
		.STATUS_TWO_O(s2), .RESULT_READY_O(rdy));
	logic hwe = 1'b0;
	logic [7:0] hadr = 8'h00;
	frs_host_model host (.clk_i(MCLK_I), .rst_n_i(RSTN_I), .go_i(go), .we_i(hwe), .adr_i(hadr),
		.done_o(done), .dat_o(hdat), .err_o(herr), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .dat_i(dat), .ack_i(ack), .err_i(err));
	task automatic results();
		$display("compares %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic e, input logic [7:0] x);
		int n;
		@(posedge MCLK_I);
		go <= 1'b1;
		hwe <= w;
		hadr <= a;
		@(posedge MCLK_I);
		go <= 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++) begin
			@(negedge MCLK_I);
		end
		if (n == 20) begin
			fail_count++;
			results();
		end
		`CHK(herr, e)
		if (!e) `CHK(hdat, {24'h0, x})
	endtask
	task automatic run(input frs_cmd_type k, input frs_event_type e, input logic v);
		@(posedge MCLK_I);
		start <= 1'b1;
		kind <= k;
		@(posedge MCLK_I);
		start <= 1'b0;
		@(posedge MCLK_I);
		evt <= e;
		inv <= v;
		@(posedge MCLK_I);
		evt <= '0;
		inv <= 1'b0;
		fin <= 1'b1;
		@(posedge MCLK_I);
		fin <= 1'b0;
	endtask
	task automatic t_bus();
		acc(1'b0, 8'h00, 1'b0, 8'h00);
		acc(1'b0, 8'h0c, 1'b0, 8'h01);
		acc(1'b1, 8'h00, 1'b1, 8'h00);
		acc(1'b0, 8'h10, 1'b1, 8'h00);
		$display("bus test done");
	endtask
	task automatic t_flags();
		// event index, kind, status one, status two, cylinder read from the medium
		logic [31:0] tab[19] = '{32'h00800000, 32'h10200000, 32'h20202000, 32'h30100000,
			32'h42040000, 32'h54040000, 32'h65040000, 32'h76020000, 32'h71020000,
			32'h72020000, 32'h70000000, 32'h80010000, 32'h90010100, 32'ha3004000,
			32'ha1000000, 32'hb3000800, 32'hc3000400, 32'hd00412ff, 32'hd0041005};
		frs_event_type e;
		foreach (tab[i]) begin
			e = '0;
			e[29 - tab[i][31:28]] = 1'b1;
			e[15:0] = {tab[i][7:0], 8'h03};
			run(frs_cmd_type'(tab[i][26:24]), e, 1'b0);
			acc(1'b0, 8'h00, 1'b0, tab[i][23:16]);
			acc(1'b0, 8'h04, 1'b0, tab[i][15:8]);
			`CHK(s1, tab[i][23:16])
			`CHK(s2, tab[i][15:8])
			`CHK(rdy, 1'b1)
			acc(1'b0, 8'h08, 1'b0, (tab[i][23:16] | tab[i][15:8] & 8'hf7) != 0 ? 8'h40 : 8'h00);
		end
		$display("flag test done");
	endtask
	task automatic t_invalid();
		// an invalid command never starts, so it arrives outside execution
		@(posedge MCLK_I);
		inv <= 1'b1;
		@(posedge MCLK_I);
		inv <= 1'b0;
		acc(1'b0, 8'h08, 1'b0, 8'h80);
		acc(1'b0, 8'h0c, 1'b0, 8'h02);
		$display("invalid test done");
	endtask
	initial begin
		repeat (8) @(posedge MCLK_I);
		RSTN_I <= 1'b1;
		t_bus();
		t_flags();
		t_invalid();
		results();
	end
endmodule
